// ===== hw/fault_recovery_pkg.sv
package fault_recovery_pkg;

	// ------------------------------------------------------------
	// command codes of the two registers
	// ------------------------------------------------------------
	localparam logic [7:0] CMD_FAULT_RECOVERY_POLICY = 8'hD2;
	localparam logic [7:0] CMD_OVERVOLTAGE_THRESHOLD = 8'hD3;

	// ------------------------------------------------------------
	// field layout
	// ------------------------------------------------------------
	localparam int         POLICY_W         = 10;   // bits 9:0 stored, 15:10 read zero
	localparam int         DATA_W           = 16;
	localparam int         FAULT_LO         = 2;    // first protected fault bit
	localparam int         FAULT_HI         = 9;    // last protected fault bit
	localparam int         OV_CODE_W        = 3;    // bits 2:0, bits 7:3 read zero

	// fault bit positions inside policy, mask and history words
	localparam int         BIT_INPUT_OV     = 2;
	localparam int         BIT_EXT_OVERTEMP = 3;
	localparam int         BIT_AVG_OC       = 4;
	localparam int         BIT_PEAK_OC      = 5;
	localparam int         BIT_OUTPUT_UV    = 6;
	localparam int         BIT_OUTPUT_OV    = 7;
	localparam int         BIT_LOOP_SHORT   = 8;
	localparam int         BIT_MIN_FREQ     = 9;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [9:0] POLICY_RESET_HIGH = 10'h3FF;  // strap tied high
	localparam logic [9:0] POLICY_RESET_LOW  = 10'h000;  // strap tied low
	localparam logic [2:0] OV_CODE_RESET     = 3'h6;     // 120 percent

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam longint     CLOCK_HZ        = 10_000_000;
	localparam longint     RESTART_WAIT_MS = 500;
	localparam longint     RESTART_WAIT_CYCLES = RESTART_WAIT_MS * CLOCK_HZ / 1000;
	localparam int         TIMER_W         = 23;

	// ------------------------------------------------------------
	// sequencer states
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_OFF        = 3'h0,
		ST_SOFT_START = 3'h1,
		ST_RUN        = 3'h2,
		ST_WAIT       = 3'h3,
		ST_LATCHED    = 3'h4
	} recovery_state_t;

endpackage

// ===== hw/restart_timer_if.sv
`timescale 1ns/1ps
interface restart_timer_if;
	logic start;    // one-cycle pulse: begin a full wait
	logic expired;  // one-cycle pulse: wait is over

	modport ctrl  (output start, input expired);
	modport timer (input start, output expired);
endinterface

// ===== hw/pin_sync.sv
`timescale 1ns/1ps
module pin_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             i_clock,
	input  wire logic [WIDTH-1:0] i_async,
	output logic      [WIDTH-1:0] o_sync
);

	// ------------------------------------------------------------
	// two-stage synchroniser, one per bit
	// ------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < WIDTH; g++) begin : g_bit
			logic stage1;
			logic stage2;
			// first stage feeds only the second
			always_ff @(posedge i_clock) begin
				stage1 <= i_async[g];
				stage2 <= stage1;
			end
			assign o_sync[g] = stage2;
		end
	endgenerate

endmodule

// ===== hw/restart_timer.sv
`timescale 1ns/1ps
module restart_timer #(
	parameter longint CYCLES = fault_recovery_pkg::RESTART_WAIT_CYCLES
) (
	input  wire logic     i_clock,
	input  wire logic     i_rst,
	restart_timer_if.timer tmr
);

	logic [fault_recovery_pkg::TIMER_W-1:0] count;
	logic [fault_recovery_pkg::TIMER_W-1:0] next_count;
	logic                                   running;
	logic                                   next_running;
	logic                                   expired;
	logic                                   next_expired;

	// ------------------------------------------------------------
	// down counter; a new start restarts the full wait
	// ------------------------------------------------------------
	always_comb begin
		next_count   = count;
		next_running = running;
		next_expired = 1'b0;
		if (tmr.start) begin
			next_count   = fault_recovery_pkg::TIMER_W'(CYCLES - 1);
			next_running = 1'b1;
		end else if (running) begin
			if (count == '0) begin
				next_running = 1'b0;
				next_expired = 1'b1;
			end else begin
				next_count = count - 1'b1;
			end
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			count   <= '0;
			running <= 1'b0;
			expired <= 1'b0;
		end else begin
			count   <= next_count;
			running <= next_running;
			expired <= next_expired;
		end
	end

	assign tmr.expired = expired;

endmodule

// ===== hw/fault_recovery_and_ov_limit.sv
// Behaviour
// - strap high loads ten ones, low zeros
// - policy bit one restarts, zero latches off
// - restart: stop, wait, soft-start, repeat
// - latch-off: stay stopped after fault clears
// - command port keeps working while latched
// - leave latch only by enable toggle, reset
// - policy bits 2..9 map to eight faults
// - policy register two bytes, writable, protectable
// - three-bit code selects overvoltage threshold
// - threshold code resets to 110
// - overvoltage detection active from soft-start
// - overvoltage sets history bit, pulls alert
// - overvoltage acted on by default policy
// - threshold register one byte, bits 7:3 unused
// - masked fault takes no protective action
// - history bit set once fault seen in run, or in soft-start for all but undervoltage
`timescale 1ns/1ps
module fault_recovery_and_ov_limit #(
	parameter longint RESTART_WAIT_CYCLES = fault_recovery_pkg::RESTART_WAIT_CYCLES
) (
	input  wire logic        i_clock,
	input  wire logic        i_rst,
	input  wire logic        i_recovery_strap_pin,
	input  wire logic        i_enable_pin,
	input  wire logic [9:2]  i_fault,
	input  wire logic [9:2]  i_fault_mask,
	input  wire logic        i_soft_start_done,
	input  wire logic        i_history_clear,
	input  wire logic [7:0]  i_cmd_code,
	input  wire logic        i_cmd_write,
	input  wire logic        i_cmd_read,
	input  wire logic [15:0] i_write_data,
	input  wire logic        i_write_protect,
	output logic [15:0]      o_read_data,
	output logic             o_read_valid,
	output logic             o_cmd_unsupported,
	output logic [2:0]       o_overvoltage_code,
	output logic             o_switch_enable,
	output logic             o_soft_start_request,
	output logic             o_latched_off,
	output logic [9:2]       o_fault_history,
	output logic             o_alert_out_n
);

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	logic       strap_sync;
	logic       enable_sync;
	logic [9:2] fault_sync;

	pin_sync #(
		.WIDTH (10)
	) u_pin_sync (
		.i_clock (i_clock),
		.i_async ({i_recovery_strap_pin, i_enable_pin, i_fault}),
		.o_sync  ({strap_sync, enable_sync, fault_sync})
	);

	// ------------------------------------------------------------
	// restart wait timer
	// ------------------------------------------------------------
	restart_timer_if tmr_bus ();

	restart_timer #(
		.CYCLES (RESTART_WAIT_CYCLES)
	) u_restart_timer (
		.i_clock (i_clock),
		.i_rst   (i_rst),
		.tmr     (tmr_bus.timer)
	);

	// ------------------------------------------------------------
	// register state
	// ------------------------------------------------------------
	logic [9:0]  policy;
	logic [9:0]  next_policy;
	logic [2:0]  ov_code;
	logic [2:0]  next_ov_code;
	logic [15:0] read_data;
	logic [15:0] next_read_data;
	logic        read_valid;
	logic        next_read_valid;
	logic        unsupported;
	logic        next_unsupported;

	logic        hit_policy;
	logic        hit_ov;
	logic        write_ok;

	assign hit_policy = (i_cmd_code == fault_recovery_pkg::CMD_FAULT_RECOVERY_POLICY);
	assign hit_ov     = (i_cmd_code == fault_recovery_pkg::CMD_OVERVOLTAGE_THRESHOLD);
	// protected writes are dropped silently
	assign write_ok   = i_cmd_write && !i_write_protect;

	// command decode; nothing here depends on the sequencer state
	always_comb begin
		next_policy      = policy;
		next_ov_code     = ov_code;
		next_read_data   = read_data;
		next_read_valid  = 1'b0;
		next_unsupported = 1'b0;
		if (write_ok && hit_policy) begin
			next_policy = i_write_data[fault_recovery_pkg::POLICY_W-1:0];
		end
		if (write_ok && hit_ov) begin
			next_ov_code = i_write_data[fault_recovery_pkg::OV_CODE_W-1:0];
		end
		if (i_cmd_read) begin
			next_read_valid = 1'b1;
			if (hit_policy) begin
				next_read_data = {6'h00, policy};
			end else if (hit_ov) begin
				next_read_data = {13'h0000, ov_code};
			end else begin
				next_read_data = 16'h0000;
			end
		end
		if ((i_cmd_read || i_cmd_write) && !hit_policy && !hit_ov) begin
			next_unsupported = 1'b1;
		end
	end

	// strap level is already synchronised, so reset may sample it
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			policy      <= strap_sync ? fault_recovery_pkg::POLICY_RESET_HIGH
			                          : fault_recovery_pkg::POLICY_RESET_LOW;
			ov_code     <= fault_recovery_pkg::OV_CODE_RESET;
			read_data   <= 16'h0000;
			read_valid  <= 1'b0;
			unsupported <= 1'b0;
		end else begin
			policy      <= next_policy;
			ov_code     <= next_ov_code;
			read_data   <= next_read_data;
			read_valid  <= next_read_valid;
			unsupported <= next_unsupported;
		end
	end

	// ------------------------------------------------------------
	// fault qualification
	// ------------------------------------------------------------
	fault_recovery_pkg::recovery_state_t state;
	fault_recovery_pkg::recovery_state_t next_state;

	logic [9:2] detect_window;
	logic [9:2] active_fault;
	logic       any_fault;
	logic       any_latch;

	// undervoltage only after soft-start, all others from its start
	always_comb begin
		detect_window = 8'h00;
		if (state == fault_recovery_pkg::ST_SOFT_START || state == fault_recovery_pkg::ST_RUN) begin
			detect_window = 8'hFF;
			if (state == fault_recovery_pkg::ST_SOFT_START) begin
				detect_window[fault_recovery_pkg::BIT_OUTPUT_UV] = 1'b0;
			end
		end
	end

	assign active_fault = fault_sync & ~i_fault_mask & detect_window;
	assign any_fault    = |active_fault;
	// policy bit lines up with fault bit
	// overvoltage follows its own policy bit
	assign any_latch    = |(active_fault & ~policy[9:2]);

	// ------------------------------------------------------------
	// fault history and alert
	// ------------------------------------------------------------
	logic [9:2] history;
	logic [9:2] next_history;

	// a fault arriving with the clear still sets its bit
	always_comb begin
		next_history = history;
		if (i_history_clear) begin
			next_history = 8'h00;
		end
		next_history = next_history | (fault_sync & detect_window);
	end

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			history <= 8'h00;
		end else begin
			history <= next_history;
		end
	end

	// ------------------------------------------------------------
	// recovery sequencer
	// ------------------------------------------------------------
	logic timer_start;

	always_comb begin
		next_state  = state;
		timer_start = 1'b0;
		unique case (state)
			fault_recovery_pkg::ST_OFF: begin
				if (enable_sync) begin
					next_state = fault_recovery_pkg::ST_SOFT_START;
				end
			end
			fault_recovery_pkg::ST_SOFT_START,
			fault_recovery_pkg::ST_RUN: begin
				if (!enable_sync) begin
					next_state = fault_recovery_pkg::ST_OFF;
				end else if (any_latch) begin
					next_state = fault_recovery_pkg::ST_LATCHED;
				end else if (any_fault) begin
					next_state  = fault_recovery_pkg::ST_WAIT;
					timer_start = 1'b1;
				end else if (state == fault_recovery_pkg::ST_SOFT_START && i_soft_start_done) begin
					next_state = fault_recovery_pkg::ST_RUN;
				end
			end
			fault_recovery_pkg::ST_WAIT: begin
				if (!enable_sync) begin
					next_state = fault_recovery_pkg::ST_OFF;
				end else if (tmr_bus.expired) begin
					next_state = fault_recovery_pkg::ST_SOFT_START;
				end
			end
			fault_recovery_pkg::ST_LATCHED: begin
				// only enable low releases the latch
				if (!enable_sync) begin
					next_state = fault_recovery_pkg::ST_OFF;
				end
			end
			default: begin
				next_state = fault_recovery_pkg::ST_OFF;
			end
		endcase
	end

	assign tmr_bus.start = timer_start;

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			state <= fault_recovery_pkg::ST_OFF;
		end else begin
			state <= next_state;
		end
	end

	// ------------------------------------------------------------
	// registered outputs to the power stage
	// ------------------------------------------------------------
	logic switch_enable;
	logic next_switch_enable;
	logic soft_start_request;
	logic next_soft_start_request;
	logic latched_off;
	logic next_latched_off;
	logic alert_n;
	logic next_alert_n;

	// decoded from the next state so outputs track it with one flop
	always_comb begin
		next_switch_enable      = (next_state == fault_recovery_pkg::ST_SOFT_START) ||
		                          (next_state == fault_recovery_pkg::ST_RUN);
		next_soft_start_request = (next_state == fault_recovery_pkg::ST_SOFT_START);
		next_latched_off        = (next_state == fault_recovery_pkg::ST_LATCHED);
		// alert low while any history bit set
		next_alert_n            = ~|next_history;
	end

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			switch_enable      <= 1'b0;
			soft_start_request <= 1'b0;
			latched_off        <= 1'b0;
			alert_n            <= 1'b1;
		end else begin
			switch_enable      <= next_switch_enable;
			soft_start_request <= next_soft_start_request;
			latched_off        <= next_latched_off;
			alert_n            <= next_alert_n;
		end
	end

	// ------------------------------------------------------------
	// port drive
	// ------------------------------------------------------------
	// code straight to the comparator selector
	assign o_overvoltage_code   = ov_code;
	assign o_read_data          = read_data;
	assign o_read_valid         = read_valid;
	assign o_cmd_unsupported    = unsupported;
	assign o_switch_enable      = switch_enable;
	assign o_soft_start_request = soft_start_request;
	assign o_latched_off        = latched_off;
	assign o_fault_history      = history;
	assign o_alert_out_n        = alert_n;

endmodule

// ===== test/fault_recovery_monitor.sv
`timescale 1ns/1ps
// ----------------------------------------
// port checker
// ----------------------------------------
module fault_recovery_monitor (
	input wire logic        i_clock,
	input wire logic        i_rst,
	input wire logic        i_enable_pin,
	input wire logic [7:0]  i_cmd_code,
	input wire logic        i_cmd_write,
	input wire logic        i_cmd_read,
	input wire logic [15:0] i_write_data,
	input wire logic        i_write_protect,
	input wire logic        o_read_valid,
	input wire logic        o_cmd_unsupported,
	input wire logic [2:0]  o_overvoltage_code,
	input wire logic        o_switch_enable,
	input wire logic        o_soft_start_request,
	input wire logic        o_latched_off,
	input wire logic [9:2]  o_fault_history,
	input wire logic        o_alert_out_n
);
	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (i_rst);

	// the two codes the port answers
	wire known = (i_cmd_code == 8'hD2) || (i_cmd_code == 8'hD3);

	// pin held long enough to pass the two-flop sync
	sequence en_held;
		i_enable_pin [*4];
	endsequence
	sequence en_dropped;
		!i_enable_pin [*5];
	endsequence

	a_read_answer: assert property (
		i_cmd_read && known |=> o_read_valid && !o_cmd_unsupported)
		else $error("read of a known code not answered");
	a_unknown_code: assert property (
		(i_cmd_read || i_cmd_write) && !known |=> o_cmd_unsupported)
		else $error("unknown code not refused");
	a_unsup_cause: assert property (
		o_cmd_unsupported |-> $past(i_cmd_read || i_cmd_write))
		else $error("refusal without a command");
	a_code_write: assert property (
		i_cmd_write && !i_write_protect && i_cmd_code == 8'hD3
		|=> o_overvoltage_code == $past(i_write_data[2:0]))
		else $error("threshold code not written");
	a_code_protect: assert property (
		i_cmd_write && i_write_protect |=> $stable(o_overvoltage_code))
		else $error("protected write changed threshold");
	a_alert_history: assert property (
		o_alert_out_n == !(|o_fault_history))
		else $error("alert does not follow history");
	a_ramp_switching: assert property (
		o_soft_start_request |-> o_switch_enable)
		else $error("soft-start without switching");
	a_latch_stops: assert property (
		o_latched_off |-> !o_switch_enable && !o_soft_start_request)
		else $error("switching while latched");
	a_latch_holds: assert property (
		en_held ##0 o_latched_off |=> o_latched_off)
		else $error("latch left with enable high");
	a_disable_stops: assert property (
		en_dropped |=> !o_switch_enable && !o_latched_off)
		else $error("still active with enable low");
endmodule

// ===== test/power_stage_model.sv
`timescale 1ns/1ps
// boost stage ramp: done comes a fixed time after soft-start begins
module power_stage_model #(
	parameter int RAMP = 12
) (
	input  wire logic i_clock,
	input  wire logic i_soft_start_request,
	output logic      o_soft_start_done
);
	int count = 0;

	always @(posedge i_clock) begin
		count <= i_soft_start_request ? count + 1 : 0;
	end
	assign o_soft_start_done = i_soft_start_request && (count >= RAMP);
endmodule

// ===== test/fault_recovery_and_ov_limit_test.sv
`timescale 1ns/1ps
module fault_recovery_and_ov_limit_test;
	localparam longint WAIT = 20;
	logic        i_clock = 0;
	logic        rst = 1;
	logic        strap = 1;
	logic        enable = 0;
	logic [9:2]  fault = '0;
	logic [9:2]  mask = '0;
	logic        ramp_done;
	logic        hclear = 0;
	logic [7:0]  code = 8'h00;
	logic        wr = 0;
	logic        rd = 0;
	logic [15:0] wdata = 16'h0000;
	logic        wprot = 0;
	logic [15:0] rdata;
	logic        rvalid;
	logic        unsup;
	logic [2:0]  ov_code;
	logic        sw_en;
	logic        ss_req;
	logic        latched;
	logic [9:2]  history;
	logic        alert_n;
	int          mismatches = 0;
	int          checks = 0;
	int          policy;
	int          ov;
	int          n;

	// 10 MHz clock
	always #50 i_clock = ~i_clock;

	fault_recovery_and_ov_limit #(.RESTART_WAIT_CYCLES(WAIT)) uut (
		.i_clock(i_clock), .i_rst(rst), .i_recovery_strap_pin(strap),
		.i_enable_pin(enable), .i_fault(fault), .i_fault_mask(mask),
		.i_soft_start_done(ramp_done), .i_history_clear(hclear),
		.i_cmd_code(code), .i_cmd_write(wr), .i_cmd_read(rd),
		.i_write_data(wdata), .i_write_protect(wprot), .o_read_data(rdata),
		.o_read_valid(rvalid), .o_cmd_unsupported(unsup),
		.o_overvoltage_code(ov_code), .o_switch_enable(sw_en),
		.o_soft_start_request(ss_req), .o_latched_off(latched),
		.o_fault_history(history), .o_alert_out_n(alert_n));

	power_stage_model stage (.i_clock(i_clock), .i_soft_start_request(ss_req),
		.o_soft_start_done(ramp_done));

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic stop_test;
		if (mismatches == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic cycles(input int k);
		repeat (k) @(negedge i_clock);
	endtask

	// one command; its answer is settled at the following falling edge
	task automatic cmd(input logic w, input logic [7:0] c, input logic [15:0] d);
		@(negedge i_clock);
		wr = w;
		rd = !w;
		code = c;
		wdata = d;
		@(negedge i_clock);
		wr = 0;
		rd = 0;
	endtask

	task automatic rd_expect(input logic [7:0] c, input logic [15:0] exp);
		cmd(0, c, 16'h0000);
		check({15'h0000, rvalid}, 16'h0001);
		check(rdata, exp);
	endtask

	// reset also stands for power-on; model follows the strap
	task automatic do_reset(input logic s);
		strap = s;
		rst = 1;
		enable = 0;
		fault = '0;
		cycles(12);
		rst = 0;
		policy = s ? 32'h3FF : 0;
		ov = 6;
	endtask

	task automatic power_up;
		enable = 1;
		cycles(25);
		check({14'h0000, sw_en, ss_req}, 16'h0002);
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		void'($urandom(25092));
		do_reset(1);
		rd_expect(8'hD2, 16'h03FF);
		rd_expect(8'hD3, 16'h0006);
		// every threshold code, junk in the unused bits
		for (int c = 0; c < 8; c++) begin
			ov = c;
			cmd(1, 8'hD3, {13'($urandom), 3'(c)});
			rd_expect(8'hD3, 16'(ov));
			check(16'(ov_code), 16'(ov));
		end
		wprot = 1;
		cmd(1, 8'hD3, 16'h0001);
		cmd(1, 8'hD2, 16'h0000);
		wprot = 0;
		rd_expect(8'hD3, 16'(ov));
		rd_expect(8'hD2, 16'(policy));
		cmd(0, 8'hD4, 16'h0000);
		check({15'h0000, unsup}, 16'h0001);
		policy = 16'($urandom);
		cmd(1, 8'hD2, 16'(policy));
		policy = policy & 32'h3FF;
		rd_expect(8'hD2, 16'(policy));
		// each fault latches when its own policy bit is clear
		for (int b = 2; b <= 9; b++) begin
			policy = 32'h3FF ^ (1 << b);
			cmd(1, 8'hD2, 16'(policy));
			power_up();
			fault[b] = 1;
			cycles(5);
			fault[b] = 0;
			cycles(10);
			check({13'h0000, sw_en, latched, alert_n}, 16'h0002);
			check(16'(history), 16'(1 << (b - 2)));
			rd_expect(8'hD2, 16'(policy));
			enable = 0;
			cycles(6);
			check({15'h0000, latched}, 16'h0000);
			hclear = 1;
			cycles(1);
			hclear = 0;
			cycles(2);
			check({7'h00, history, alert_n}, 16'h0001);
		end
		// overvoltage during soft-start, auto-restart policy
		policy = 32'h3FF;
		cmd(1, 8'hD2, 16'h03FF);
		enable = 1;
		cycles(5);
		fault[7] = 1;
		cycles(5);
		check({14'h0000, sw_en, latched}, 16'h0000);
		check({7'h00, history, alert_n}, 16'h0040);
		for (n = 0; n < 100 && !sw_en; n++) @(negedge i_clock);
		for (n = 0; n < 100 && sw_en; n++) @(negedge i_clock);
		for (n = 0; n < 100 && !sw_en; n++) @(negedge i_clock);
		check(16'(n), 16'(WAIT + 1));
		fault[7] = 0;
		cycles(60);
		check({14'h0000, sw_en, ss_req}, 16'h0002);
		// masked fault leaves switching alone
		mask[5] = 1;
		fault[5] = 1;
		cycles(8);
		check({15'h0000, sw_en}, 16'h0001);
		mask[5] = 0;
		do_reset(0);
		rd_expect(8'hD2, 16'h0000);
		stop_test();
	end

	// hang guard
	initial begin
		#1_000_000;
		mismatches++;
		stop_test();
	end
endmodule

bind fault_recovery_and_ov_limit fault_recovery_monitor mon (
	.i_clock(i_clock), .i_rst(i_rst), .i_enable_pin(i_enable_pin),
	.i_cmd_code(i_cmd_code), .i_cmd_write(i_cmd_write), .i_cmd_read(i_cmd_read),
	.i_write_data(i_write_data), .i_write_protect(i_write_protect),
	.o_read_valid(o_read_valid), .o_cmd_unsupported(o_cmd_unsupported),
	.o_overvoltage_code(o_overvoltage_code), .o_switch_enable(o_switch_enable),
	.o_soft_start_request(o_soft_start_request), .o_latched_off(o_latched_off),
	.o_fault_history(o_fault_history), .o_alert_out_n(o_alert_out_n));
